//--- core/gpb_pkg.sv
// Functional notes
// - eight pins, each independently input or output
// - direction bit one: pin input, driver off unless pwm or serial owns the pin
// - direction bit zero: drive pin from latch unless analogue or owned by pwm or serial
// - data read returns sampled pin levels, analogue pins read zero
// - data write loads latch regardless of direction
// - pins zero to three feed converter channels
// - pin4 capture, pin5 pwm, pins6-7 serial
// - reset makes pins three to zero analogue
// - data and direction registers sit in bank five
package gpb_pkg;
   localparam int          PORT_W       = 8;        // pins on the port
   localparam int          ANA_W        = 4;        // pins shared with converter
   localparam int          BANK_W       = 4;        // bank select width
   localparam int          ADDR_W       = 8;        // in-bank address width
   localparam logic [3:0]  PORT_BANK    = 4'h5;     // bank holding the port
   localparam logic [7:0]  OFS_DATA     = 8'h10;    // eight_bit_port offset
   localparam logic [7:0]  OFS_DIR      = 8'h11;    // pin_direction_reg offset
   localparam logic [7:0]  OFS_ANA      = 8'h12;    // converter_config_reg offset
   localparam logic [7:0]  RST_LATCH    = 8'h00;    // output latch after reset
   localparam logic [7:0]  RST_DIR      = 8'hff;    // all pins input after reset
   localparam logic [3:0]  RST_ANA      = 4'hf;     // low pins analogue after reset
   localparam int          BIT_CAPTURE  = 4;        // capture_shared_pin
   localparam int          BIT_PWM      = 5;        // pwm_shared_pin
   localparam int          BIT_UART_LO  = 6;        // uart_shared_pin_lo, transmit
   localparam int          BIT_UART_HI  = 7;        // uart_shared_pin_hi, receive
endpackage

//--- core/gpb_pin_sync.sv
`timescale 1ns/100ps
// two-stage synchroniser for asynchronous pin levels
module gpb_pin_sync #(
   parameter int W      = 8,
   parameter int STAGES = 2
) (
   input  wire logic          clock,
   input  wire logic          rst,
   input  wire logic [W-1:0]  async_in,
   output logic      [W-1:0]  sync_out
);
   // refuse a chain too short to settle metastability
   if (STAGES < 2) begin : g_bad_stages
      $error("gpb_pin_sync needs at least two stages");
   end

   // all synchroniser state in one record
   typedef struct packed {
      logic [STAGES-1:0][W-1:0] chain;   // chain[0] is read only by chain[1]
   } gpb_sync_t;

   gpb_sync_t sync_reg;    // registered chain
   gpb_sync_t sync_next;   // next chain

   // shift by one stage each clock
   always_comb begin
      sync_next          = sync_reg;
      sync_next.chain[0] = async_in;
      for (int i = 1; i < STAGES; i++) begin
         sync_next.chain[i] = sync_reg.chain[i-1];
      end
   end

   // chain cleared on reset
   always_ff @(posedge clock) begin
      if (rst) begin
         sync_reg <= '0;
      end else begin
         sync_reg <= sync_next;
      end
   end

   assign sync_out = sync_reg.chain[STAGES-1];
endmodule // gpb_pin_sync

//--- core/gpb_port.sv
`timescale 1ns/100ps
// eight-bit bidirectional port behind the banked register file
module gpb_port
   import gpb_pkg::*;
#(
   parameter int SYNC_STAGES = 2
) (
   input  wire logic                clock,
   input  wire logic                rst,
   input  wire logic [BANK_W-1:0]   bank_select_reg,
   input  wire logic [ADDR_W-1:0]   reg_addr,
   input  wire logic                reg_wr,
   input  wire logic [PORT_W-1:0]   reg_wdata,
   input  wire logic                reg_rd,
   output logic      [PORT_W-1:0]   reg_rdata,
   input  wire logic [PORT_W-1:0]   pin_in,
   output logic      [PORT_W-1:0]   pin_out,
   output logic      [PORT_W-1:0]   pin_oe,
   output logic      [ANA_W-1:0]    analog_shared_pins,
   output logic                     third_capture_input,
   input  wire logic                pwm_enable,
   input  wire logic                third_pwm_output,
   input  wire logic                serial_enable,
   input  wire logic                serial_tx,
   output logic                     serial_rx
);
   // refuse a synchroniser too short to settle metastability
   if (SYNC_STAGES < 2) begin : g_bad_sync
      $error("gpb_port needs SYNC_STAGES of at least two");
   end
   // the peripheral bit positions must exist on the port
   if (ANA_W > BIT_CAPTURE || BIT_UART_HI >= PORT_W) begin : g_bad_bits
      $error("gpb_port peripheral pins fall outside the port");
   end

   // all block state in one record
   typedef struct packed {
      logic [PORT_W-1:0] latch;      // output latch
      logic [PORT_W-1:0] dir;        // one = input
      logic [ANA_W-1:0]  ana;        // one = analogue pin
      logic [PORT_W-1:0] rdata;      // read answer
      logic [PORT_W-1:0] pout;       // pin drive level
      logic [PORT_W-1:0] poe;        // pin driver enable
      logic              cap;        // capture level to peripheral
      logic              rx;         // receive level to serial port
   } gpb_state_t;

   gpb_state_t          st_reg;     // registered state
   gpb_state_t          st_next;    // next state
   logic [PORT_W-1:0]   pin_sync;   // pins after the synchroniser

   // address match inside the port bank
   function automatic logic gpb_hit(input logic [BANK_W-1:0] bank,
                                    input logic [ADDR_W-1:0] addr,
                                    input logic [ADDR_W-1:0] ofs);
      return (bank == PORT_BANK) && (addr == ofs);
   endfunction

   // pins are asynchronous to the core clock
   gpb_pin_sync #(
      .W      (PORT_W),
      .STAGES (SYNC_STAGES)
   ) u_sync (
      .clock    (clock),
      .rst      (rst),
      .async_in (pin_in),
      .sync_out (pin_sync)
   );

   // next-state logic
   always_comb begin
      st_next = st_reg;
      // writes; latch loads whatever the direction is
      if (reg_wr && gpb_hit(bank_select_reg, reg_addr, OFS_DATA)) begin
         st_next.latch = reg_wdata;
      end
      // direction bits: one keeps the pin an input
      if (reg_wr && gpb_hit(bank_select_reg, reg_addr, OFS_DIR)) begin
         st_next.dir = reg_wdata;
      end
      // converter config: low four bits only, upper write bits dropped
      if (reg_wr && gpb_hit(bank_select_reg, reg_addr, OFS_ANA)) begin
         st_next.ana = reg_wdata[ANA_W-1:0];
      end
      // reads; unmapped or other bank answers zero
      if (reg_rd) begin
         st_next.rdata = '0;
         if (gpb_hit(bank_select_reg, reg_addr, OFS_DATA)) begin
            // live pins; analogue pins read low since digital input is off
            st_next.rdata = pin_sync & ~{{(PORT_W-ANA_W){1'b0}}, st_reg.ana};
         end else if (gpb_hit(bank_select_reg, reg_addr, OFS_DIR)) begin
            st_next.rdata = st_reg.dir;
         end else if (gpb_hit(bank_select_reg, reg_addr, OFS_ANA)) begin
            st_next.rdata = {{(PORT_W-ANA_W){1'b0}}, st_reg.ana};
         end
      end
      // default drive: latch when direction is zero
      st_next.pout = st_reg.latch;
      st_next.poe  = ~st_reg.dir;
      // analogue pins never drive
      st_next.poe[ANA_W-1:0] = ~st_reg.dir[ANA_W-1:0] & ~st_reg.ana;
      // pwm takes over its pin while enabled
      if (pwm_enable) begin
         st_next.pout[BIT_PWM] = third_pwm_output;
         st_next.poe[BIT_PWM]  = 1'b1;
      end
      // serial port owns both of its pins while enabled
      if (serial_enable) begin
         st_next.pout[BIT_UART_LO] = serial_tx;
         st_next.poe[BIT_UART_LO]  = 1'b1;
         st_next.poe[BIT_UART_HI]  = 1'b0;
      end
      // peripheral inputs always see the pin level
      st_next.cap = pin_sync[BIT_CAPTURE];
      st_next.rx  = pin_sync[BIT_UART_HI];
   end

   // state register; reset leaves pins input and low pins analogue
   always_ff @(posedge clock) begin
      if (rst) begin
         st_reg       <= '0;
         st_reg.latch <= RST_LATCH;
         st_reg.dir   <= RST_DIR;
         st_reg.ana   <= RST_ANA;
      end else begin
         st_reg <= st_next;
      end
   end

   // peripheral enables win over direction bits on pins five to seven
   // outputs straight from flip-flops
   assign reg_rdata           = st_reg.rdata;
   assign pin_out             = st_reg.pout;
   assign pin_oe              = st_reg.poe;
   assign analog_shared_pins  = st_reg.ana;
   assign third_capture_input = st_reg.cap;
   assign serial_rx           = st_reg.rx;

   // properties guarding the port rules
   // all but the reset check stay quiet while rst is high
   a_input_no_drive: assert property (@(posedge clock) disable iff (rst)
      (st_reg.dir[3] && st_reg.dir[2]) |=> (!pin_oe[3] && !pin_oe[2]))
      else $error("input pin driven");

   a_output_latch: assert property (@(posedge clock) disable iff (rst)
      (!st_reg.dir[4]) |=> (pin_oe[4] && pin_out[4] == $past(st_reg.latch[4])))
      else $error("output pin not driven from latch");

   a_read_pins: assert property (@(posedge clock) disable iff (rst)
      (reg_rd && bank_select_reg == PORT_BANK && reg_addr == OFS_DATA)
      |=> reg_rdata[7:4] == $past(pin_sync[7:4]))
      else $error("data read not from pins");

   a_write_latch: assert property (@(posedge clock) disable iff (rst)
      (reg_wr && bank_select_reg == PORT_BANK && reg_addr == OFS_DATA)
      |=> st_reg.latch == $past(reg_wdata))
      else $error("latch not written");

   a_other_bank: assert property (@(posedge clock) disable iff (rst)
      (bank_select_reg != PORT_BANK) |=> $stable(st_reg.latch) && $stable(st_reg.dir))
      else $error("port changed from wrong bank");

   a_reset_analog: assert property (@(posedge clock)
      rst |=> (analog_shared_pins == RST_ANA && pin_oe == '0))
      else $error("reset did not make low pins analogue");

   a_analog_quiet: assert property (@(posedge clock) disable iff (rst)
      (st_reg.ana[0] && !st_reg.dir[0]) |=> !pin_oe[0])
      else $error("analogue pin driven");

   a_keep_latch: assert property (@(posedge clock) disable iff (rst)
      (st_reg.dir[7] && !(reg_wr && bank_select_reg == PORT_BANK && reg_addr == OFS_DATA))
      ##1 (!st_reg.dir[7] && !serial_enable)
      |=> (pin_oe[7] && pin_out[7] == $past(st_reg.latch[7], 2)))
      else $error("stored level not driven after direction clear");

   a_capture_path: assert property (@(posedge clock) disable iff (rst)
      ##1 third_capture_input == $past(pin_sync[BIT_CAPTURE]))
      else $error("capture input not following pin");

   a_input_off: assert property (@(posedge clock) disable iff (rst)
      (!pwm_enable && !serial_enable) |=> ((pin_oe & $past(st_reg.dir)) == '0))
      else $error("input pin has its driver on");

   a_drive_mask: assert property (@(posedge clock) disable iff (rst)
      (!pwm_enable && !serial_enable)
      |=> (pin_oe == (~$past(st_reg.dir) & {{(PORT_W-ANA_W){1'b1}}, ~$past(st_reg.ana)})))
      else $error("driver enables differ from direction and analogue bits");

   a_drive_level: assert property (@(posedge clock) disable iff (rst)
      (!pwm_enable && !serial_enable) |=> (pin_out == $past(st_reg.latch)))
      else $error("pin drive level not from latch");

   a_pwm_owns: assert property (@(posedge clock) disable iff (rst)
      pwm_enable |=> (pin_oe[BIT_PWM] && pin_out[BIT_PWM] == $past(third_pwm_output)))
      else $error("pwm pin not handed to pwm level");

   a_serial_owns: assert property (@(posedge clock) disable iff (rst)
      serial_enable |=> (pin_oe[BIT_UART_LO] && !pin_oe[BIT_UART_HI]
                         && pin_out[BIT_UART_LO] == $past(serial_tx)))
      else $error("serial pins not handed to serial port");

   a_rx_path: assert property (@(posedge clock) disable iff (rst)
      1'b1 |=> serial_rx == $past(pin_sync[BIT_UART_HI]))
      else $error("receive input not following pin");

   a_dir_write: assert property (@(posedge clock) disable iff (rst)
      (reg_wr && bank_select_reg == PORT_BANK && reg_addr == OFS_DIR)
      |=> st_reg.dir == $past(reg_wdata))
      else $error("direction register not written");

   a_foreign_read: assert property (@(posedge clock) disable iff (rst)
      (reg_rd && bank_select_reg != PORT_BANK) |=> reg_rdata == '0)
      else $error("read from wrong bank not zero");

   a_unmapped_read: assert property (@(posedge clock) disable iff (rst)
      (reg_rd && bank_select_reg == PORT_BANK && reg_addr != OFS_DATA
       && reg_addr != OFS_DIR && reg_addr != OFS_ANA)
      |=> reg_rdata == '0)
      else $error("read of unmapped address not zero");

   a_rdata_hold: assert property (@(posedge clock) disable iff (rst)
      !reg_rd |=> $stable(reg_rdata))
      else $error("read answer changed without a read");
endmodule // gpb_port

//--- sim/gpb_pin_model.sv
`timescale 1ns/100ps
// outside world of the port: a driven pin echoes the port, a released one shows ext_lvl
module gpb_pin_model
   import gpb_pkg::*;
(
   input  wire logic [PORT_W-1:0] pin_out,
   input  wire logic [PORT_W-1:0] pin_oe,
   input  wire logic [PORT_W-1:0] ext_lvl,
   output logic      [PORT_W-1:0] pin_in
);
   // wire level resolved from both parties, never the stale port value
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_lvl);
endmodule // gpb_pin_model

//--- sim/tb_eight_bit_bidir_port.sv
`timescale 1ns/100ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin fail_count++; \
   $display("ERROR %0t: got %h exp %h", $time, g, e); end end
module tb_eight_bit_bidir_port;
   import gpb_pkg::*;
   logic       clock = 0, rst = 1, reg_wr = 0, reg_rd = 0;
   logic       pwm_enable = 0, pwm_lvl = 0, serial_enable = 0, serial_tx = 0;
   logic [3:0] bank = 0;
   logic [7:0] addr = 0, wdata = 0, rdata, pin_in, pin_out, pin_oe, ext = 0;
   logic [7:0] r, a, d, m, p;
   logic [3:0] ana;
   logic       cap, rx;
   int         fail_count = 0, n_compared = 0;
   always #2.5 clock = ~clock;
   gpb_port uut (.clock(clock), .rst(rst), .bank_select_reg(bank), .reg_addr(addr),
      .reg_wr(reg_wr), .reg_wdata(wdata), .reg_rd(reg_rd), .reg_rdata(rdata),
      .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .analog_shared_pins(ana),
      .third_capture_input(cap), .pwm_enable(pwm_enable), .third_pwm_output(pwm_lvl),
      .serial_enable(serial_enable), .serial_tx(serial_tx), .serial_rx(rx));
   gpb_pin_model pins (.pin_out(pin_out), .pin_oe(pin_oe), .ext_lvl(ext), .pin_in(pin_in));
   // expected driver enables: analogue pins never drive
   function automatic logic [7:0] f_oe(logic [7:0] dir, logic [3:0] an);
      f_oe = ~dir & {4'hf, ~an};
   endfunction
   // expected data read: live pin levels, analogue bits read 0
   function automatic logic [7:0] f_rd(logic [7:0] dir, lat, ex, logic [3:0] an);
      f_rd = ((~dir & lat) | (dir & ex)) & {4'hf, ~an};
   endfunction
   // one-cycle write strobe, launched just after an edge
   task automatic wr(logic [3:0] b, logic [7:0] ad, logic [7:0] dt);
      @(posedge clock);
      #1 bank = b;
      addr   = ad;
      wdata  = dt;
      reg_wr = 1;
      @(posedge clock);
      #1 reg_wr = 0;
   endtask
   // one-cycle read strobe; answer is registered at the next edge, then sampled 1 ns later
   task automatic rd(logic [3:0] b, logic [7:0] ad, output logic [7:0] q);
      @(posedge clock);
      #1 bank = b;
      addr   = ad;
      reg_rd = 1;
      @(posedge clock);
      #1 reg_rd = 0;
      q = rdata;
   endtask
   task automatic settle();
      repeat (5) @(posedge clock);
      #1;
   endtask
   task automatic end_sim();
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // watchdog: whole run needs a few hundred cycles
   initial begin
      #20000;
      fail_count++;
      end_sim();
   end
   initial begin
      void'($urandom(22240));
      ext = 8'($urandom);
      p   = RST_DIR;
      repeat (4) @(posedge clock);
      #1 rst = 0;
      settle();
      // reset state: all inputs, low pins analogue
      `CHK(pin_oe, 8'h00)
      `CHK(ana, RST_ANA)
      rd(PORT_BANK, OFS_DATA, r);
      `CHK(r, {ext[7:4], 4'h0})
      for (int i = 0; i < 12; i++) begin
         a   = 8'($urandom);
         d   = 8'($urandom);
         m   = 8'($urandom);
         ext = 8'($urandom);
         // typical bring-up: low pins digital
         if (i == 0) begin
            a = 8'h00;
            m = 8'h03;
         end
         wr(PORT_BANK, OFS_ANA, a);
         wr(PORT_BANK, OFS_DATA, d);
         // latch written first: drivers still follow the old direction
         `CHK(pin_oe, f_oe(p, a[3:0]))
         wr(PORT_BANK, OFS_DIR, m);
         wr(4'h4, OFS_DATA, ~d); // other bank: must not touch the latch
         settle();
         `CHK(pin_oe, f_oe(m, a[3:0]))
         `CHK(pin_out & pin_oe, d & pin_oe)
         `CHK(ana, a[3:0])
         rd(PORT_BANK, OFS_DATA, r);
         `CHK(r, f_rd(m, d, ext, a[3:0]))
         rd(PORT_BANK, OFS_DIR, r);
         `CHK(r, m)
         rd(PORT_BANK, OFS_ANA, r);
         `CHK(r, {4'h0, a[3:0]})
         rd(4'h4, OFS_DATA, r);
         `CHK(r, 8'h00)
         rd(PORT_BANK, OFS_ANA + 8'h01, r);
         `CHK(r, 8'h00)
         p = m;
      end
      // shared upper pins: pwm and serial take over, capture and rx follow
      wr(PORT_BANK, OFS_DIR, 8'hff);
      ext           = 8'h90;
      pwm_enable    = 1;
      pwm_lvl       = 1;
      serial_enable = 1;
      serial_tx     = 0;
      settle();
      `CHK(pin_oe[7:4], 4'b0110)
      `CHK(pin_out[6:5], 2'b01)
      `CHK({rx, cap}, 2'b11)
      ext       = 8'h00;
      pwm_lvl   = 0;
      serial_tx = 1;
      settle();
      `CHK(pin_out[6:5], 2'b10)
      `CHK({rx, cap}, 2'b00)
      // second reset in mid-run: all pins input again, low pins analogue
      pwm_enable    = 0;
      serial_enable = 0;
      @(posedge clock);
      #1 rst = 1;
      repeat (4) @(posedge clock);
      #1 rst = 0;
      `CHK(pin_oe, 8'h00)
      `CHK(ana, RST_ANA)
      rd(PORT_BANK, OFS_DIR, r);
      `CHK(r, RST_DIR)
      // upper pins made outputs: the reset latch level appears
      wr(PORT_BANK, OFS_DIR, 8'h0f);
      settle();
      `CHK(pin_oe, 8'hf0)
      `CHK(pin_out[7:4], RST_LATCH[7:4])
      end_sim();
   end
endmodule // tb_eight_bit_bidir_port
